/* dv/adcc_host_model.sv */
// Host side model of the parallel data lines
`timescale 1ns/10ps
module adcc_host_model #(parameter int DATA_W = 14) (
    // Pins from the converter
    input wire logic ref_clk,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic [DATA_W-1:0] dataOutEn,
    // Wire level and captured word
    output logic [DATA_W-1:0] wireData,
    output logic [DATA_W-1:0] capData
);
    logic [DATA_W-1:0] lastWire = '0;
    // Released lines show the inverse of the last level so stale data never matches
    always_comb wireData = (dataOut & dataOutEn) | (~lastWire & ~dataOutEn);
    always @(posedge ref_clk) begin
        lastWire <= wireData;
        capData <= wireData;
    end
endmodule : adcc_host_model

/* dv/adcc_ports_sva.sv */
// Port checker of the converter control block
`timescale 1ns/10ps
module adcc_ports_sva #(parameter int DATA_W = 14, parameter int WAKE_CYCLES = 16) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic convReset,
    input wire logic readEnable_n,
    input wire logic sleep_request_n,
    input wire logic signed [DATA_W:0] quantIn,
    // Results
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic [DATA_W-1:0] dataOutEn,
    input wire logic validFlag_n,
    input wire logic calBusy,
    input wire logic asleep
);
    localparam int WAKE_MAX = WAKE_CYCLES + 4;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Overflow shows as the two top bits differing
    function automatic logic [DATA_W-1:0] sat(input logic [DATA_W:0] v);
        return (v[DATA_W] == v[DATA_W-1]) ? v[DATA_W-1:0]
            : {v[DATA_W], {(DATA_W-1){~v[DATA_W]}}};
    endfunction : sat
    property p_en; $past(rstn) |-> dataOutEn == {DATA_W{!$past(readEnable_n)}}; endproperty
    a_en: assert property (p_en) else $error("drive enable mismatch");
    property p_data; !validFlag_n |-> dataOut == sat($past(quantIn, 14)); endproperty
    a_data: assert property (p_data) else $error("valid word mismatch");
    property p_sleepIn; !sleep_request_n |=> asleep; endproperty
    a_sleepIn: assert property (p_sleepIn) else $error("sleep not entered");
    property p_sleepFlag; asleep |-> validFlag_n; endproperty
    a_sleepFlag: assert property (p_sleepFlag) else $error("valid while asleep");
    property p_rstCal; convReset |=> !calBusy; endproperty
    a_rstCal: assert property (p_rstCal) else $error("busy during reset");
    property p_rstFlag; convReset |=> validFlag_n; endproperty
    a_rstFlag: assert property (p_rstFlag) else $error("valid during reset");
    property p_calFall; $fell(calBusy) |-> validFlag_n [*8]; endproperty
    a_calFall: assert property (p_calFall) else $error("valid too soon");
    property p_wake; $rose(sleep_request_n) |-> ##[1:WAKE_MAX] !asleep; endproperty
    a_wake: assert property (p_wake) else $error("wake too slow");
endmodule : adcc_ports_sva
bind adc_control_and_readout adcc_ports_sva #(.DATA_W(DATA_W), .WAKE_CYCLES(WAKE_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .convReset(convReset), .readEnable_n(readEnable_n),
    .sleep_request_n(sleep_request_n), .quantIn(quantIn), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .validFlag_n(validFlag_n), .calBusy(calBusy), .asleep(asleep));

/* dv/test_adc_control_and_readout.sv */
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module test_adc_control_and_readout;
    logic ref_clk = 1'b0, rstn = 1'b0, convReset = 1'b0, calRequest = 1'b0;
    logic readEnable_n = 1'b0, sleep_request_n = 1'b1;
    logic signed [14:0] quantIn = '0;
    logic [13:0] dataOut, dataOutEn, wireData, capData;
    logic validFlag_n, calBusy, asleep;
    logic signed [14:0] hist[$];
    logic [14:0] corner[6] = '{15'h1FFF, 15'h2000, 15'h6000, 15'h5FFF, 15'h4000, 15'h0000};
    int error_cnt = 0, checks_done = 0, cyc = 0;
    adc_control_and_readout #(.CAL_CYCLES(50), .WAKE_CYCLES(4)) dut (.ref_clk(ref_clk),
        .rstn(rstn), .convReset(convReset), .calRequest(calRequest), .readEnable_n(readEnable_n),
        .sleep_request_n(sleep_request_n), .quantIn(quantIn), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .validFlag_n(validFlag_n), .calBusy(calBusy), .asleep(asleep));
    adcc_host_model host (.ref_clk(ref_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .wireData(wireData), .capData(capData));
    always #5 ref_clk = ~ref_clk;
    function automatic logic [13:0] sat(input logic [14:0] v);
        return (v[14] == v[13]) ? v[13:0] : {v[14], {13{~v[14]}}};
    endfunction : sat
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk) begin
        hist.push_front(quantIn);
        if (hist.size() > 20) void'(hist.pop_back());
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // Random words with full-scale and overrange corners mixed in
    task automatic stream(input int n, output int first);
        logic wasValid;
        first = -1;
        wasValid = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            // The host register holds the word that stood before the last rising edge
            if (wasValid) begin
                check("capture", {2'h0, sat(hist[14])}, {2'h0, capData});
            end
            wasValid = (validFlag_n === 1'b0);
            if (validFlag_n === 1'b0) begin
                if (first < 0) first = i;
                check("dataWire", {2'h0, sat(hist[13])}, {2'h0, wireData});
                check("driveEn", 16'h3FFF, {2'h0, dataOutEn});
            end
            quantIn = (i % 3 == 0) ? corner[(i / 3) % 6] : 15'($urandom);
        end
    endtask : stream
    task automatic reset_run(input string name);
        int first;
        convReset = 1'b1;
        tick(2);
        convReset = 1'b0;
        stream(60, first);
        check("validDelay", 16'h1, {15'h0, (first >= 13 && first <= 20)});
        $display("test %s done", name);
    endtask : reset_run
    initial begin
        int cnt, first;
        void'($urandom(90));
        tick(6);
        rstn = 1'b1;
        reset_run("reset_run");
        tick(4);
        calRequest = 1'b1;
        tick(2);
        calRequest = 1'b0;
        cnt = 0;
        while (calBusy === 1'b1 && cnt < 100) begin
            check("calFlag", 16'h1, {15'h0, validFlag_n});
            tick(1);
            cnt++;
        end
        check("calLength", 16'h1, {15'h0, (cnt >= 48 && cnt <= 54)});
        stream(60, first);
        check("calValid", 16'h1, {15'h0, (first >= 13 && first <= 20)});
        $display("test calibration done");
        readEnable_n = 1'b1;
        tick(2);
        check("driveOff", 16'h0, {2'h0, dataOutEn});
        readEnable_n = 1'b0;
        sleep_request_n = 1'b0;
        tick(3);
        check("asleep", 16'h1, {15'h0, asleep});
        check("sleepFlag", 16'h1, {15'h0, validFlag_n});
        sleep_request_n = 1'b1;
        cnt = 0;
        while (asleep === 1'b1 && cnt < 20) begin
            tick(1);
            cnt++;
        end
        check("wake", 16'h1, {15'h0, (cnt <= 8)});
        $display("test sleep done");
        rstn = 1'b0;
        tick(2);
        check("rstFlag", 16'h1, {15'h0, validFlag_n});
        check("rstEn", 16'h0, {2'h0, dataOutEn});
        rstn = 1'b1;
        // A one-edge reset pulse is too short and must not start conversions
        convReset = 1'b1;
        tick(1);
        convReset = 1'b0;
        tick(20);
        check("shortPulse", 16'h1, {15'h0, validFlag_n});
        reset_run("sleep_recover");
        calRequest = 1'b1;
        tick(2);
        calRequest = 1'b0;
        tick(5);
        check("calStart", 16'h1, {15'h0, calBusy});
        reset_run("cal_abort");
        check("abortBusy", 16'h0, {15'h0, calBusy});
        report_and_stop();
    end
endmodule : test_adc_control_and_readout

/* src/adc_control_and_readout.sv */
// Control sequencing and parallel readout of a pipelined 14-bit converter
`timescale 1ns/10ps
`include "adcc_consts.svh"
module adc_control_and_readout #(
    parameter int DATA_W = `ADCC_DATA_W,
    parameter int CAL_CYCLES = `ADCC_CAL_CYCLES,
    parameter int WAKE_CYCLES = `ADCC_WAKE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Control pins
    input wire logic convReset,
    input wire logic calRequest,
    input wire logic readEnable_n,
    input wire logic sleep_request_n,
    // Quantiser result, signed, one per clock
    input wire logic signed [DATA_W:0] quantIn,
    // Data pins
    output logic [DATA_W-1:0] dataOut,
    output logic [DATA_W-1:0] dataOutEn,
    output logic validFlag_n,
    // Status
    output logic calBusy,
    output logic asleep
);
    localparam int CNT_W = $clog2(CAL_CYCLES + 1);

    // Mode, counters and every registered output kept in one word
    typedef struct packed {
        adcc_pkg::adcc_mode_e mode;
        logic [CNT_W-1:0] count;
        logic [1:0] reqCount;
        logic [DATA_W-1:0] dataOut;
        logic [DATA_W-1:0] dataOutEn;
        logic validFlag_n;
        logic calBusy;
        logic asleep;
    } adcc_top_s;

    adcc_top_s state_ff;
    adcc_top_s nxt_state;
    logic [DATA_W-1:0] clampWord;
    logic [DATA_W-1:0] pipeWord;
    logic pipeValid;
    logic pipeFlush;

    // Overrange input saturates; two's complement keeps sign in the top bit
    function automatic logic [DATA_W-1:0] clamp(input logic signed [DATA_W:0] v);
        logic signed [DATA_W:0] hi;
        logic signed [DATA_W:0] lo;
        hi = $signed({1'b0, `ADCC_POS_FULL});
        lo = $signed({1'b1, `ADCC_NEG_FULL});
        if (v > hi) begin
            clamp = `ADCC_POS_FULL;
        end else if (v < lo) begin
            clamp = `ADCC_NEG_FULL;
        end else begin
            clamp = v[DATA_W-1:0];
        end
    endfunction : clamp

    // Saturating count of edges a request pin has been seen high
    function automatic logic [1:0] holdCount(input logic [1:0] c);
        if (c == 2'h3) begin
            holdCount = c;
        end else begin
            holdCount = c + 2'h1;
        end
    endfunction : holdCount

    // A pulse is honoured only once it has stood for the minimum number of edges
    function automatic logic heldLongEnough(input logic [1:0] c);
        heldLongEnough = (c >= 2'(`ADCC_REQ_MIN_CYCLES));
    endfunction : heldLongEnough

    assign clampWord = clamp(quantIn);
    // Any non-run mode empties the pipe, so the first run word arrives 13 later
    assign pipeFlush = (state_ff.mode != adcc_pkg::ST_RUN) || convReset
        || calRequest || !sleep_request_n;

    adcc_pipe #(
        .DATA_W(DATA_W),
        .DEPTH(`ADCC_PIPE_DEPTH)
    ) u_pipe (
        // Samples in flight are held only while the clock keeps running
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sampleIn(clampWord),
        .sampleValid(1'b1),
        .flush(pipeFlush),
        .wordOut(pipeWord),
        .wordValid(pipeValid)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.reqCount = 2'h0;
        case (state_ff.mode)
            adcc_pkg::ST_SLEEP: begin
                nxt_state.count = '0;
                if (sleep_request_n) begin
                    nxt_state.mode = adcc_pkg::ST_WAKE;
                end
            end
            adcc_pkg::ST_WAKE: begin
                // Wake time counted on the running clock
                // Reset and calibration requests during wake are ignored; the host must reset afterwards
                if (state_ff.count == CNT_W'(WAKE_CYCLES - 1)) begin
                    nxt_state.mode = adcc_pkg::ST_IDLE;
                    nxt_state.count = '0;
                end else begin
                    nxt_state.count = state_ff.count + CNT_W'(1);
                end
            end
            adcc_pkg::ST_IDLE, adcc_pkg::ST_RUN: begin
                // Reset wins when both requests rise together
                if (convReset) begin
                    nxt_state.mode = adcc_pkg::ST_RESET;
                    nxt_state.reqCount = 2'h1;
                end else if (calRequest) begin
                    nxt_state.mode = adcc_pkg::ST_CALREQ;
                    nxt_state.reqCount = 2'h1;
                end
            end
            adcc_pkg::ST_RESET: begin
                nxt_state.reqCount = state_ff.reqCount;
                if (convReset) begin
                    nxt_state.reqCount = holdCount(state_ff.reqCount);
                end else if (heldLongEnough(state_ff.reqCount)) begin
                    nxt_state.mode = adcc_pkg::ST_RUN;
                end else begin
                    // Too short a pulse leaves the converter idle
                    nxt_state.mode = adcc_pkg::ST_IDLE;
                end
            end
            adcc_pkg::ST_CALREQ: begin
                nxt_state.reqCount = state_ff.reqCount;
                if (convReset) begin
                    nxt_state.mode = adcc_pkg::ST_RESET;
                    nxt_state.reqCount = 2'h1;
                end else if (calRequest) begin
                    nxt_state.reqCount = holdCount(state_ff.reqCount);
                end else if (heldLongEnough(state_ff.reqCount)) begin
                    nxt_state.mode = adcc_pkg::ST_CAL;
                    nxt_state.count = '0;
                end else begin
                    nxt_state.mode = adcc_pkg::ST_IDLE;
                end
            end
            adcc_pkg::ST_CAL: begin
                // Reset aborts a calibration, which must then be run again
                if (convReset) begin
                    nxt_state.mode = adcc_pkg::ST_RESET;
                    nxt_state.reqCount = 2'h1;
                end else if (state_ff.count == CNT_W'(CAL_CYCLES - 1)) begin
                    nxt_state.mode = adcc_pkg::ST_RUN;
                    nxt_state.count = '0;
                end else begin
                    nxt_state.count = state_ff.count + CNT_W'(1);
                end
            end
            default: begin
                nxt_state.mode = adcc_pkg::ST_IDLE;
            end
        endcase
        // Sleep overrides every mode, taking effect at the next ref_clk edge
        if (!sleep_request_n) begin
            nxt_state.mode = adcc_pkg::ST_SLEEP;
            nxt_state.count = '0;
        end
        nxt_state.calBusy = (nxt_state.mode == adcc_pkg::ST_CAL)
            || (nxt_state.mode == adcc_pkg::ST_CALREQ);
        nxt_state.asleep = (nxt_state.mode == adcc_pkg::ST_SLEEP);
        // Pipe output is trusted only in run mode with no request pending
        nxt_state.dataOut = pipeWord;
        nxt_state.validFlag_n = !(pipeValid && !pipeFlush);
        // Enable lags the pin by one edge, like every other output pin
        nxt_state.dataOutEn = readEnable_n ? '0 : '1;
    end

    always_ff @(posedge ref_clk) begin
        // Synchronous reset puts every output at its idle level
        if (!rstn) begin
            state_ff.mode <= adcc_pkg::ST_IDLE;
            state_ff.count <= '0;
            state_ff.reqCount <= 2'h0;
            state_ff.dataOut <= '0;
            state_ff.dataOutEn <= '0;
            state_ff.validFlag_n <= 1'b1;
            state_ff.calBusy <= 1'b0;
            state_ff.asleep <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dataOut = state_ff.dataOut;
    assign dataOutEn = state_ff.dataOutEn;
    assign validFlag_n = state_ff.validFlag_n;
    assign calBusy = state_ff.calBusy;
    assign asleep = state_ff.asleep;
endmodule : adc_control_and_readout

/* src/adcc_consts.svh */
// Timing counts and fixed codes of the converter control block
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_DATA_W 14
`define ADCC_PIPE_DEPTH 13
`define ADCC_CAL_CYCLES 272800
`define ADCC_REQ_MIN_CYCLES 2
`define ADCC_WAKE_CYCLES 16
`define ADCC_NEG_FULL 14'h2000
`define ADCC_POS_FULL 14'h1FFF
`define ADCC_SIGN_BIT 13
`endif

/* src/adcc_pipe.sv */
// Sample pipeline with per-stage validity, thirteen stages deep
`timescale 1ns/10ps
`include "adcc_consts.svh"
module adcc_pipe #(
    parameter int DATA_W = `ADCC_DATA_W,
    parameter int DEPTH = `ADCC_PIPE_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Stage input
    input wire logic [DATA_W-1:0] sampleIn,
    input wire logic sampleValid,
    input wire logic flush,
    // Stage output
    output logic [DATA_W-1:0] wordOut,
    output logic wordValid
);
    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] data;
        logic [DEPTH-1:0] valid;
    } adcc_pipe_s;

    adcc_pipe_s state_ff;
    adcc_pipe_s nxt_state;

    always_comb begin
        nxt_state = state_ff;
        for (int i = DEPTH - 1; i > 0; i--) begin
            nxt_state.data[i] = state_ff.data[i-1];
            nxt_state.valid[i] = state_ff.valid[i-1];
        end
        nxt_state.data[0] = sampleIn;
        nxt_state.valid[0] = sampleValid;
        // Words in flight lose their meaning on reset, calibration or sleep
        if (flush) begin
            nxt_state.valid = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wordOut = state_ff.data[DEPTH-1];
    assign wordValid = state_ff.valid[DEPTH-1];
endmodule : adcc_pipe

/* src/adcc_pkg.sv */
// Types of the converter control block
package adcc_pkg;
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_WAKE,
        ST_IDLE,
        ST_RESET,
        ST_CALREQ,
        ST_CAL,
        ST_RUN
    } adcc_mode_e;
endpackage : adcc_pkg
